// ==== verilog/gpcp_consts.svh ====
// Offsets, field positions and reset values of the clock and pin control page
`ifndef GPCP_CONSTS_SVH
`define GPCP_CONSTS_SVH
`define GPCP_IDX_AUX_CLK 5'h0D
`define GPCP_IDX_PIN_LED 5'h0E
`define GPCP_IDX_LINK_LOSS 5'h13
`define GPCP_IDX_LINE_CLK 5'h17
`define GPCP_IDX_PAGE_SEL 5'h1F
`define GPCP_PAGE_MAIN 16'h0000
`define GPCP_PAGE_GP 16'h0010
`define GPCP_MASK_AUX_CLK 16'hE000
`define GPCP_MASK_PIN_LED 16'h3200
`define GPCP_MASK_LINK_LOSS 16'h000F
`define GPCP_MASK_LINE_CLK 16'h8737
`define GPCP_RST_AUX_CLK 16'h0000
`define GPCP_RST_PIN_LED 16'h2200
`define GPCP_RST_LINK_LOSS 16'h0000
`define GPCP_RST_LINE_CLK 16'h0000
`define GPCP_BIT_AUX_EN 15
`define GPCP_BIT_AUX_SEL_HI 14
`define GPCP_BIT_AUX_SEL_LO 13
`define GPCP_BIT_PD_OE_N 13
`define GPCP_BIT_PD_OUT 12
`define GPCP_BIT_PD_IN 11
`define GPCP_BIT_LED_TRI 9
`define GPCP_LL_HI 3
`define GPCP_LL_ENABLED 4'h0
`define GPCP_LL_DISABLED 4'hF
`define GPCP_BIT_LC_EN 15
`define GPCP_LC_FREQ_HI 10
`define GPCP_LC_FREQ_LO 8
`define GPCP_LC_SQ_HI 5
`define GPCP_LC_SQ_LO 4
`define GPCP_LC_SRC_HI 2
`define GPCP_LC_SRC_COPPER 3'h1
`define GPCP_AUX_SEL_RSVD 2'h3
`define GPCP_LED_NUM 2
`define GPCP_ADDR_TOP 12'h07C
`endif

// ==== verilog/gpcp_pkg.sv ====
// Types shared by the clock and pin control page
package gpcp_pkg;
  // Squelch policy of the line-derived clock
  typedef enum logic [1:0] {
    GPCP_SQ_STRICT = 2'h0,
    GPCP_SQ_RELAXED = 2'h1,
    GPCP_SQ_LINK_ONLY = 2'h2,
    GPCP_SQ_OFF = 2'h3
  } gpcp_squelch_t;
  // Link condition reported by the copper core
  typedef struct packed {
    logic link_up;
    logic link_stable;
    logic speed_100;
    logic eee_active;
    logic lpi_rx;
  } gpcp_link_stat_t;
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gpcp_apb_req_t;
endpackage

// ==== verilog/gpcp_page.sv ====
// General purpose page: clock outputs, power-down pin, LEDs, link loss pin
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "gpcp_consts.svh"
module gpcp_page
  import gpcp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire gpcp_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic aux_clock_output_en_o,
  output logic [1:0] aux_clock_output_sel_o,
  input wire logic global_power_down_pin_i,
  output logic global_power_down_pin_o,
  output logic global_power_down_pin_oe_o,
  input wire logic [`GPCP_LED_NUM-1:0] led_i,
  output logic [`GPCP_LED_NUM-1:0] led_o,
  output logic [`GPCP_LED_NUM-1:0] led_oe_o,
  input wire logic link_loss_i,
  output logic quick_link_loss_pin_o,
  input wire gpcp_link_stat_t link_stat_i,
  input wire logic clk_mute_i,
  input wire logic copper_clk_i,
  output logic line_derived_clock_output_o,
  output logic [2:0] line_clk_freq_o
);

  // Merge write data into writable bits, reserved bits stay zero
  function automatic logic [15:0] gpcp_merge(input logic [15:0] wd,
                                             input logic [15:0] mask);
    gpcp_merge = wd & mask;
  endfunction

  logic [15:0] page_q;
  logic [15:0] aux_q;
  logic [15:0] pin_q;
  logic [15:0] ll_q;
  logic [15:0] lc_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic pd_oe_q;
  logic pd_out_q;
  logic [`GPCP_LED_NUM-1:0] led_q;
  logic [`GPCP_LED_NUM-1:0] led_oe_q;
  logic ll_pin_q;
  logic lc_out_q;
  logic aux_en_q;
  logic [1:0] aux_sel_q;
  logic [2:0] lc_freq_q;

  // Bus decode
  wire setup_w = apb_i.psel & ~apb_i.penable;
  wire done_w = apb_i.psel & apb_i.penable & pready_q;
  wire wr_w = done_w & apb_i.pwrite;
  wire [4:0] idx_w = apb_i.paddr[6:2];
  wire bad_w = (apb_i.paddr > `GPCP_ADDR_TOP) | (apb_i.paddr[1:0] != 2'h0);
  wire gp_w = (page_q == `GPCP_PAGE_GP);
  wire sel_page_w = ~bad_w & (idx_w == `GPCP_IDX_PAGE_SEL);
  wire sel_aux_w = ~bad_w & gp_w & (idx_w == `GPCP_IDX_AUX_CLK);
  wire sel_pin_w = ~bad_w & gp_w & (idx_w == `GPCP_IDX_PIN_LED);
  wire sel_ll_w = ~bad_w & gp_w & (idx_w == `GPCP_IDX_LINK_LOSS);
  wire sel_lc_w = ~bad_w & gp_w & (idx_w == `GPCP_IDX_LINE_CLK);

  // Live pin level folded into the pin register on read
  wire [15:0] pin_rd_w = pin_q |
    ({15'h0000, global_power_down_pin_i} << `GPCP_BIT_PD_IN);

  // Read mux; main page and reserved addresses read zero
  wire [15:0] rd_w =
    sel_page_w ? page_q :
    sel_aux_w ? aux_q :
    sel_pin_w ? pin_rd_w :
    sel_ll_w ? ll_q :
    sel_lc_w ? lc_q : 16'h0000;

  // Response registered at setup so the access phase ends at once
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup_w;
      pslverr_q <= setup_w & bad_w;
      prdata_q <= setup_w ? {16'h0000, rd_w} : 32'h0000_0000;
    end
  end

  // Page select is not sticky: a soft reset returns the main page
  always_ff @(posedge clock_i)
  begin
    if (rst_i | soft_reset_i)
      page_q <= `GPCP_PAGE_MAIN;
    else if (wr_w & sel_page_w)
      page_q <= apb_i.pwdata[15:0];
  end

  // Page registers ignore soft reset; only power-on reset loads their defaults
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      aux_q <= `GPCP_RST_AUX_CLK;
      pin_q <= `GPCP_RST_PIN_LED;
      ll_q <= `GPCP_RST_LINK_LOSS;
      lc_q <= `GPCP_RST_LINE_CLK;
    end
    else if (wr_w)
    begin
      if (sel_aux_w)
        aux_q <= gpcp_merge(apb_i.pwdata[15:0], `GPCP_MASK_AUX_CLK);
      if (sel_pin_w)
        pin_q <= gpcp_merge(apb_i.pwdata[15:0], `GPCP_MASK_PIN_LED);
      if (sel_ll_w)
        ll_q <= gpcp_merge(apb_i.pwdata[15:0], `GPCP_MASK_LINK_LOSS);
      if (sel_lc_w)
        lc_q <= gpcp_merge(apb_i.pwdata[15:0], `GPCP_MASK_LINE_CLK);
    end
  end

  // Field views
  wire [1:0] aux_sel_w = aux_q[`GPCP_BIT_AUX_SEL_HI:`GPCP_BIT_AUX_SEL_LO];
  wire [3:0] ll_set_w = ll_q[`GPCP_LL_HI:0];
  wire [2:0] lc_src_w = lc_q[`GPCP_LC_SRC_HI:0];
  wire [2:0] lc_freq_w = lc_q[`GPCP_LC_FREQ_HI:`GPCP_LC_FREQ_LO];
  gpcp_squelch_t sq_w;
  assign sq_w = gpcp_squelch_t'(lc_q[`GPCP_LC_SQ_HI:`GPCP_LC_SQ_LO]);

  // Squelch decision per policy level
  wire base_bad_w = ~link_stat_i.link_up | ~link_stat_i.link_stable;
  wire sq_strict_w = base_bad_w | ~link_stat_i.speed_100 |
                     link_stat_i.eee_active;
  wire sq_relax_w = base_bad_w |
                    (link_stat_i.eee_active & ~link_stat_i.lpi_rx);
  wire sq_link_w = ~link_stat_i.link_up;
  logic squelch_w;
  always_comb
  begin
    case (sq_w)
      GPCP_SQ_STRICT: squelch_w = sq_strict_w;
      GPCP_SQ_RELAXED: squelch_w = sq_relax_w;
      GPCP_SQ_LINK_ONLY: squelch_w = sq_link_w;
      GPCP_SQ_OFF: squelch_w = 1'b0;
      default: squelch_w = 1'b1;
    endcase
  end

  // Reserved sources carry no clock, so they behave as squelched
  wire src_ok_w = (lc_src_w == `GPCP_LC_SRC_COPPER);
  wire lc_pass_w = lc_q[`GPCP_BIT_LC_EN] & src_ok_w & ~squelch_w &
                   ~clk_mute_i;

  // Line clock leaves through a flop; it adds one cycle of latency
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      lc_out_q <= 1'b0;
      lc_freq_q <= 3'h0;
    end
    else
    begin
      lc_out_q <= lc_pass_w & copper_clk_i;
      lc_freq_q <= lc_freq_w;
    end
  end

  // Aux clock settings go to the clock generator; reserved select stays off
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      aux_en_q <= 1'b0;
      aux_sel_q <= 2'h0;
    end
    else
    begin
      aux_en_q <= aux_q[`GPCP_BIT_AUX_EN] &
                  (aux_sel_w != `GPCP_AUX_SEL_RSVD);
      aux_sel_q <= aux_sel_w;
    end
  end

  // Power-down pin direction and data
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pd_oe_q <= 1'b0;
      pd_out_q <= 1'b0;
    end
    else
    begin
      pd_oe_q <= ~pin_q[`GPCP_BIT_PD_OE_N];
      pd_out_q <= pin_q[`GPCP_BIT_PD_OUT];
    end
  end

  // LEDs: in tri-state mode a high is left to the external pull-up
  wire led_tri_w = pin_q[`GPCP_BIT_LED_TRI];
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      led_q <= '0;
      led_oe_q <= '0;
    end
    else
    begin
      led_q <= led_i;
      led_oe_q <= led_tri_w ? ~led_i : {`GPCP_LED_NUM{1'b1}};
    end
  end

  // Link loss pin only follows the core when enabled; reserved is off
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      ll_pin_q <= 1'b0;
    else
      ll_pin_q <= (ll_set_w == `GPCP_LL_ENABLED) & link_loss_i;
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign aux_clock_output_en_o = aux_en_q;
  assign aux_clock_output_sel_o = aux_sel_q;
  assign global_power_down_pin_o = pd_out_q;
  assign global_power_down_pin_oe_o = pd_oe_q;
  assign led_o = led_q;
  assign led_oe_o = led_oe_q;
  assign quick_link_loss_pin_o = ll_pin_q;
  assign line_derived_clock_output_o = lc_out_q;
  assign line_clk_freq_o = lc_freq_q;

  // Checks; each label names the rule it guards
  AST_PAGE_MAP: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (wr_w && sel_page_w && apb_i.pwdata[15:0] == `GPCP_PAGE_GP
     && !soft_reset_i) |=> gp_w)
    else $error("page select did not map general page");
  AST_PAGE_MAIN: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (wr_w && sel_page_w && apb_i.pwdata[15:0] == `GPCP_PAGE_MAIN)
    |=> !gp_w)
    else $error("main page not restored");
  AST_STICKY: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (soft_reset_i && !wr_w) |=> $stable(lc_q) && $stable(pin_q))
    else $error("page bits lost on soft reset");
  AST_AUX_EN: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (aux_q[15:13] == 3'h4) |=> aux_clock_output_en_o)
    else $error("aux clock not enabled");
  AST_AUX_RSVD: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (aux_sel_w == `GPCP_AUX_SEL_RSVD) |=> !aux_clock_output_en_o)
    else $error("aux clock enabled on reserved select");
  AST_PD_DIR: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ##1 global_power_down_pin_oe_o == !$past(pin_q[13]))
    else $error("power-down pin direction wrong");
  AST_PD_DATA: assert property (
    @(posedge clock_i) disable iff (rst_i)
    global_power_down_pin_oe_o |-> global_power_down_pin_o
      == $past(pin_q[12]))
    else $error("power-down pin data wrong");
  AST_PD_READ: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (setup_w && sel_pin_w) |=> prdata_o[11] == $past(global_power_down_pin_i))
    else $error("pin level not read back");
  AST_LED_TRI: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ($past(led_tri_w) && led_o != 2'h0) |-> (led_oe_o & led_o) == 2'h0)
    else $error("LED driven high in tri-state mode");
  // Push-pull mode must drive both levels on every LED
  AST_LED_DRIVE: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !led_tri_w |=> led_oe_o == {`GPCP_LED_NUM{1'b1}})
    else $error("LED not driven in push-pull mode");
  AST_LL_OFF: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ll_set_w == `GPCP_LL_DISABLED) |=> !quick_link_loss_pin_o)
    else $error("link loss pin active while disabled");
  AST_LL_ON: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ll_set_w == `GPCP_LL_ENABLED && link_loss_i) |=> quick_link_loss_pin_o)
    else $error("link loss pin not raised");
  AST_MUTE: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_mute_i[*2] |-> ##1 !line_derived_clock_output_o)
    else $error("clock passed while muted");
  AST_SQ_LINK: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (sq_w == GPCP_SQ_LINK_ONLY && !link_stat_i.link_up)
    |=> !line_derived_clock_output_o)
    else $error("clock passed with link down");
  AST_SQ_OFF: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (lc_q[15] && sq_w == GPCP_SQ_OFF && lc_src_w == 3'h1 && !clk_mute_i
     && copper_clk_i) |=> line_derived_clock_output_o)
    else $error("clock squelched with squelch off");
  AST_SRC_RSVD: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (lc_src_w != `GPCP_LC_SRC_COPPER) |=> !line_derived_clock_output_o)
    else $error("clock passed from reserved source");
  AST_STRICT: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (sq_w == GPCP_SQ_STRICT && link_stat_i.eee_active)
    |=> !line_derived_clock_output_o)
    else $error("clock passed in EEE at strict level");
  // Strict level carries no clock at 10 Mb/s
  AST_STRICT_10M: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (sq_w == GPCP_SQ_STRICT && !link_stat_i.speed_100)
    |=> !line_derived_clock_output_o)
    else $error("clock passed at 10M at strict level");
  // Relaxed level must pass the clock at 10M and during LPI reception
  AST_RELAX: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (sq_w == GPCP_SQ_RELAXED && lc_q[15] && lc_src_w == 3'h1 && !clk_mute_i
     && copper_clk_i && link_stat_i.link_up && link_stat_i.link_stable
     && (!link_stat_i.eee_active || link_stat_i.lpi_rx))
    |=> line_derived_clock_output_o)
    else $error("relaxed squelch too strong");
  AST_RSVD_RD: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (setup_w && !gp_w && !sel_page_w) |=> prdata_o == 32'h0000_0000)
    else $error("reserved address read nonzero");
  // A refused address answers at once, flagged, with zero data
  AST_SLVERR: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (setup_w && bad_w) |=> pready_o && pslverr_o
      && prdata_o == 32'h0000_0000)
    else $error("refused address not flagged");
  AST_FREQ: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ##1 line_clk_freq_o == $past(lc_q[10:8]))
    else $error("line clock frequency not forwarded");
  AST_LC_EN: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !lc_q[15] |=> !line_derived_clock_output_o)
    else $error("line clock output while disabled");

  COV_GP_WRITE: cover property (@(posedge clock_i) disable iff (rst_i)
    wr_w && sel_lc_w);
  COV_CLK_OUT: cover property (@(posedge clock_i) disable iff (rst_i)
    line_derived_clock_output_o);
  COV_PD_OUT: cover property (@(posedge clock_i) disable iff (rst_i)
    global_power_down_pin_oe_o && global_power_down_pin_o);
  COV_ERR: cover property (@(posedge clock_i) disable iff (rst_i)
    pready_o && pslverr_o);
  COV_RELAX_10M: cover property (@(posedge clock_i) disable iff (rst_i)
    sq_w == GPCP_SQ_RELAXED && !link_stat_i.speed_100
    && line_derived_clock_output_o);

endmodule // gpcp_page

// ==== verification/test_gp_register_page_clock_pin_ctrl.sv ====
// Self-checking bench of the clock and pin control page
`timescale 1ns/1ps
module test_gp_register_page_clock_pin_ctrl;
  import gpcp_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_rst = 1'b0;
  gpcp_apb_req_t apb = '0;
  logic [31:0] prdata;
  logic pready, pslverr, aux_en, pd_o, pd_oe, ll_o, line_o;
  logic [1:0] aux_sel, led_o, led_oe;
  logic [2:0] freq;
  logic pd_i = 1'b0;
  logic [1:0] led_i = 2'h0;
  logic ll_i = 1'b0;
  gpcp_link_stat_t stat = '0;
  logic mute = 1'b0;
  logic cu = 1'b0;
  int err_count = 0;
  int compares = 0;
  logic [15:0] shadow [4];
  logic [31:0] d;
  logic [11:0] adr [4] = '{12'h034, 12'h038, 12'h04C, 12'h05C};
  logic [15:0] msk [4] = '{16'hE000, 16'h3200, 16'h000F, 16'h8737};

  // 50 MHz clock
  always #10 clock_i = ~clock_i;

  gpcp_page i_gpcp_page (
    .clock_i(clock_i), .rst_i(rst_i), .soft_reset_i(soft_rst),
    .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .aux_clock_output_en_o(aux_en),
    .aux_clock_output_sel_o(aux_sel), .global_power_down_pin_i(pd_i),
    .global_power_down_pin_o(pd_o), .global_power_down_pin_oe_o(pd_oe),
    .led_i(led_i), .led_o(led_o), .led_oe_o(led_oe),
    .link_loss_i(ll_i), .quick_link_loss_pin_o(ll_o),
    .link_stat_i(stat), .clk_mute_i(mute), .copper_clk_i(cu),
    .line_derived_clock_output_o(line_o), .line_clk_freq_o(freq)
  );

  // Verdict and end of run
  task automatic end_sim;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; never assumes the wait count, bounded for hangs
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clock_i);
    apb.penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge clock_i);
      n++;
    end
    rd = prdata;
    err = pslverr;
    apb <= '0;
    if (n >= 16)
    begin
      err_count++;
      $display("mismatch at %0t: no bus answer", $time);
      end_sim;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, wd, r, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
    input logic eexp, input string what);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp, what);
    chk({31'h0000_0000, e}, {31'h0000_0000, eexp}, "slave error");
  endtask

  // Read image of a page register, pin level folded into bit 11
  function automatic logic [31:0] rexp(int k);
    logic [31:0] v;
    v = {16'h0000, shadow[k]};
    if (k == 1)
      v[11] = pd_i;
    return v;
  endfunction

  // Line clock seen at the pin for the present link condition
  function automatic logic exp_line(logic [15:0] r);
    logic sq;
    case (r[5:4])
      2'h0: sq = !stat.link_up || !stat.link_stable ||
        !stat.speed_100 || stat.eee_active;
      2'h1: sq = !stat.link_up || !stat.link_stable ||
        (stat.eee_active && !stat.lpi_rx);
      2'h2: sq = !stat.link_up;
      default: sq = 1'b0;
    endcase
    return cu && r[15] && r[2:0] == 3'h1 && !mute && !sq;
  endfunction

  // Pin outputs against the shadow copy; waits out the register delay
  task automatic chk_outs;
    logic [1:0] oe_x;
    repeat (3) @(posedge clock_i);
    oe_x = shadow[1][9] ? ~led_i : 2'h3;
    chk(aux_en, shadow[0][15] && shadow[0][14:13] != 2'h3, "aux");
    chk(aux_sel, shadow[0][14:13], "aux select");
    chk(pd_oe, !shadow[1][13], "pin direction");
    chk(pd_o, shadow[1][12], "pin drive");
    chk(led_o, led_i, "led level");
    chk(led_oe, oe_x, "led drive");
    chk(ll_o, shadow[2][3:0] == 4'h0 && ll_i, "loss pin");
    chk(freq, shadow[3][10:8], "line freq");
    chk(line_o, exp_line(shadow[3]), "line clock");
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(63));
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rdchk(12'h034, 32'h0000_0000, 1'b0, "main page");
    wr(12'h07C, 32'h0000_0010);
    rdchk(12'h07C, 32'h0000_0010, 1'b0, "page select");
    shadow = '{16'h0000, 16'h2200, 16'h0000, 16'h0000};
    chk_outs;
    for (int k = 0; k < 4; k++)
      rdchk(adr[k], rexp(k), 1'b0, "default");
    // Random and corner contents, inputs shuffled each round
    for (int i = 0; i < 12; i++)
    begin
      {pd_i, led_i, ll_i, stat, mute, cu} <= 11'($urandom);
      for (int k = 0; k < 4; k++)
      begin
        d = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'hFFFF_FFFF : $urandom;
        wr(adr[k], d);
        shadow[k] = d[15:0] & msk[k];
      end
      chk_outs;
      for (int k = 0; k < 4; k++)
        rdchk(adr[k], rexp(k), 1'b0, "readback");
    end
    // Every squelch level against every link condition and mute
    cu <= 1'b1;
    for (int l = 0; l < 4; l++)
    begin
      shadow[3] = {8'h80, 2'h0, l[1:0], 4'h1};
      wr(12'h05C, {16'h0000, shadow[3]});
      for (int s = 0; s < 64; s++)
      begin
        {mute, stat} <= s[5:0];
        repeat (3) @(posedge clock_i);
        chk(line_o, exp_line(shadow[3]), "squelch");
      end
    end
    // Refused and reserved places
    rdchk(12'h035, 32'h0000_0000, 1'b1, "misaligned");
    rdchk(12'h080, 32'h0000_0000, 1'b1, "beyond top");
    rdchk(12'h000, 32'h0000_0000, 1'b0, "reserved");
    wr(12'h03C, 32'hFFFF_FFFF);
    wr(12'h035, 32'hFFFF_FFFF);
    rdchk(12'h03C, 32'h0000_0000, 1'b0, "reserved write");
    rdchk(12'h034, rexp(0), 1'b0, "dropped write");
    // Soft reset keeps the page contents but leaves the page
    soft_rst <= 1'b1;
    @(posedge clock_i);
    soft_rst <= 1'b0;
    chk_outs;
    rdchk(12'h07C, 32'h0000_0000, 1'b0, "page after soft");
    rdchk(12'h05C, 32'h0000_0000, 1'b0, "main view");
    wr(12'h07C, 32'h0000_0010);
    for (int k = 0; k < 4; k++)
      rdchk(adr[k], rexp(k), 1'b0, "kept");
    wr(12'h07C, 32'h0000_0000);
    rdchk(12'h038, 32'h0000_0000, 1'b0, "back to main");
    end_sim;
  end
endmodule // test_gp_register_page_clock_pin_ctrl
